// ==== host_port_defs.vh ====
// Constants for the processor bus and display multiplexer port.
// How it works
// - Five-bit address selects the accessed register.
// - Address ignored while all strobes idle high.
// - Full mode: low strobe latches ports 1-7.
// - Full mode: high strobe ports 8-13; else unused.
// - Reduced mode: low strobe latches device display.
// - Both latch strobes high during processor access.
// - Display cycles drive data; address only full mode.
// - Data pins drive display unless read, write or load asserted.
// - Read, write, load inputs set data direction.
// - Transceiver gate high display, low access/load.
// - Ready falls once read data stable.
// - Ready falls when write data latched.
// - Event interrupt low when needed; sources maskable.
// - Event interrupt cleared by accessing its source.
// - Packet interrupt cleared by status read; maskable.
// - Low decrement input decrements all event counters.
// - Decrement synchronised; postponed behind internal counting.
// - Low load input resets and holds all but the interrupt masks and configuration.
// - Rising load edge captures data and address.
// - Rising load edge starts display test.
// - Everything timed from one 40 MHz clock.
`ifndef HOST_PORT_DEFS_VH
`define HOST_PORT_DEFS_VH

// -----------------------------------------------------------------------------
// Clock and timing
// -----------------------------------------------------------------------------
`define CLK_PERIOD_NS     25
`define DISP_SLOT_NS      100
`define DISP_SLOT_CYC     ((`DISP_SLOT_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define TEST_LEN_CYC      16'h0400

// -----------------------------------------------------------------------------
// Register map (byte index on the five-bit select)
// -----------------------------------------------------------------------------
`define REG_EVT_CNT_BASE  5'h00
`define REG_EVT_CNT_LAST  5'h0c
`define REG_EVT_FLAGS     5'h10
`define REG_EVT_FLAGS_HI  5'h11
`define REG_EVT_MASK      5'h12
`define REG_EVT_MASK_HI   5'h13
`define REG_RT_STATUS     5'h14
`define REG_RT_MASK       5'h15
`define REG_RT_SET        5'h16
`define REG_EVT_SET       5'h17
`define REG_CONFIG        5'h18
`define REG_CONFIG_ADDR   5'h19
`define REG_DISP_LO       5'h1a
`define REG_DISP_HI       5'h1b
`define REG_DISP_DEV      5'h1c
`define REG_CNT_INC       5'h1d

// -----------------------------------------------------------------------------
// Fields and reset values
// -----------------------------------------------------------------------------
`define CFG_FULL_DISP_BIT 0
`define CFG_RESET         8'h00
`define MASK_RESET        8'hff
`define PORT_HI_TAG       8'h80
`define DISP_TEST_DATA    8'hff

`endif

// ==== host_port_display_mux.v ====
// Processor bus port with time-shared LED display update cycles.
//
// Decided for this implementation: the register addresses and the plain strobed port.
`timescale 1ns/10ps
`include "host_port_defs.vh"

module host_port_display_mux #(
    parameter NUM_PORTS   = 13,   // Network ports with an event counter.
    parameter CNT_WIDTH   = 8,    // Width of each event counter.
    parameter TEST_CYCLES = 16'h0400  // Length of display test after load.
) (
    // Clock and reset.
    input  wire        clk_sys,  // Single 40 MHz clock for every process.
    input  wire        rst,
    // Processor bus inputs.
    input  wire [4:0]  register_select_in,
    input  wire        rd_n,
    input  wire        wr_n,
    input  wire        reset_config_load_n,
    input  wire        counter_down_strobe_n,
    // Shared data pins, split into three signals.
    input  wire [7:0]  shared_data_in,
    output reg  [7:0]  shared_data_out,
    output reg         shared_data_oe,
    // Display latch strobes and bus transceiver gate.
    output reg         display_latch_strobe_lo,
    output reg         display_latch_strobe_hi,
    output reg         ext_transceiver_gate,
    // Handshake and interrupts.
    output reg         ready_n,
    output reg         event_log_irq_n,
    output reg         packet_irq_n,
    // Internal event sources from the repeater core.
    input  wire [12:0] port_event_in,
    input  wire [7:0]  packet_event_in,
    input  wire [12:0] port_disp_in,
    input  wire [7:0]  device_disp_in,
    // Configuration for the rest of the chip.
    output reg  [7:0]  config_data,
    output reg  [4:0]  config_addr
);

    // -------------------------------------------------------------------------
    // Local state
    // -------------------------------------------------------------------------
    localparam ST_IDLE  = 2'b00;  // Waiting between display slots.
    localparam ST_PUT_A = 2'b01;  // Data on pins, low group strobe pulsed.
    localparam ST_PUT_B = 2'b10;  // Data on pins, high group strobe pulsed.
    // Slot reload in cycles (each slot lasts one cycle more); only the low bits fit the slot counter.
    localparam [31:0] SLOT_RELOAD = `DISP_SLOT_CYC;

    reg [1:0]           disp_state_reg;        // Display sequencer state.
    reg [3:0]           slot_cnt_reg;          // Cycles left in the current slot.
    reg [15:0]          test_cnt_reg;          // Remaining display test cycles.
    reg                 load_d_reg;            // Previous load input level.
    reg                 dec_meta_reg;          // First decrement synchroniser stage.
    reg                 dec_sync_reg;          // Second decrement synchroniser stage.
    reg                 dec_prev_reg;          // Synchronised level one cycle ago.
    reg                 dec_pend_reg;          // Decrement waiting for a free cycle.
    reg                 rd_d_reg;              // Previous read strobe.
    reg                 wr_d_reg;              // Previous write strobe.
    reg [4:0]           addr_reg;              // Address taken on every cycle a strobe or load is active; keeps the last one.
    reg [7:0]           evt_mask_lo_reg;       // Event interrupt masks, ports 1-8.
    reg [4:0]           evt_mask_hi_reg;       // Event interrupt masks, ports 9-13.
    reg [7:0]           rt_mask_reg;           // Packet interrupt masks.
    reg [12:0]          evt_flags_reg;         // Sticky port event flags.
    reg [7:0]           rt_status_reg;         // Sticky packet interrupt status.
    reg [CNT_WIDTH-1:0] cnt_mem [0:NUM_PORTS-1]; // Port event counters.
    integer             i;

    wire load_low   = ~reset_config_load_n;
    wire load_rise  = reset_config_load_n & ~load_d_reg;
    wire rd_act     = ~rd_n;
    wire wr_act     = ~wr_n;
    wire access     = rd_act | wr_act;
    // Address is only meaningful while some strobe is active.
    wire addr_live  = access | load_low;
    wire rd_start   = rd_act & ~rd_d_reg;
    wire wr_start   = wr_act & ~wr_d_reg;
    // Write data is taken on the edge where ready falls, once our own drive
    // has left the pins, so the host byte is not mixed with display data.
    wire wr_take    = wr_act & wr_d_reg & ready_n;
    wire full_mode  = config_data[`CFG_FULL_DISP_BIT];
    wire in_test    = test_cnt_reg != 16'h0000;
    // An internal count happens whenever a port event arrives.
    wire int_count  = |port_event_in;
    wire dec_edge   = ~dec_sync_reg & dec_prev_reg;
    wire [4:0] sel  = addr_live ? register_select_in : addr_reg;

    // Counter index decode, used by read mux and clear logic.
    function is_cnt;
        input [4:0] a;
        begin
            is_cnt = (a <= `REG_EVT_CNT_LAST);
        end
    endfunction

    // -------------------------------------------------------------------------
    // Read data multiplexer
    // -------------------------------------------------------------------------
    reg [7:0] rd_data;
    always @* begin
        rd_data = 8'h00;
        if (is_cnt(sel)) begin
            rd_data = cnt_mem[sel[3:0]];
        end else begin
            case (sel)
                `REG_EVT_FLAGS:    rd_data = evt_flags_reg[7:0];
                `REG_EVT_FLAGS_HI: rd_data = {3'h0, evt_flags_reg[12:8]};
                `REG_EVT_MASK:     rd_data = evt_mask_lo_reg;
                `REG_EVT_MASK_HI:  rd_data = {3'h0, evt_mask_hi_reg};
                `REG_RT_STATUS:    rd_data = rt_status_reg;
                `REG_RT_MASK:      rd_data = rt_mask_reg;
                `REG_CONFIG:       rd_data = config_data;
                `REG_CONFIG_ADDR:  rd_data = {3'h0, config_addr};
                default:           rd_data = 8'h00;
            endcase
        end
    end

    // -------------------------------------------------------------------------
    // Display data for the current slot
    // -------------------------------------------------------------------------
    reg [7:0] disp_data;
    always @* begin
        disp_data = 8'h00;
        if (in_test) begin
            disp_data = `DISP_TEST_DATA;
        end else if (!full_mode) begin
            disp_data = device_disp_in;
        end else if (disp_state_reg == ST_PUT_B) begin
            // Port address tag shares the byte only in full mode.
            disp_data = `PORT_HI_TAG | {2'b00, port_disp_in[12:7]};
        end else begin
            disp_data = {1'b0, port_disp_in[6:0]};
        end
    end

    // -------------------------------------------------------------------------
    // Bus handshake, direction and configuration capture
    // -------------------------------------------------------------------------
    // Ready is a level that falls one cycle after the strobe is seen, which
    // gives the read mux a full cycle to settle onto the pins first.
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            load_d_reg      <= 1'b1;
            rd_d_reg        <= 1'b0;
            wr_d_reg        <= 1'b0;
            addr_reg        <= 5'h00;
            ready_n         <= 1'b1;
            shared_data_out <= 8'h00;
            shared_data_oe  <= 1'b0;
            ext_transceiver_gate <= 1'b0;
            config_data     <= `CFG_RESET;
            config_addr     <= 5'h00;
        end else begin
            load_d_reg <= reset_config_load_n;
            rd_d_reg   <= rd_act;
            wr_d_reg   <= wr_act;
            if (addr_live) begin
                addr_reg <= register_select_in;
            end
            // Ready falls after read data has stood a cycle or write is taken.
            ready_n <= ~((rd_act & rd_d_reg) | (wr_act & wr_d_reg));
            // Direction follows the strobes; load low keeps pins as inputs.
            if (load_low || wr_act) begin
                shared_data_oe  <= 1'b0;
                shared_data_out <= 8'h00;
            end else if (rd_act) begin
                shared_data_oe  <= 1'b1;
                // Captured once, so a read that clears its source stays stable.
                if (rd_start) begin
                    shared_data_out <= rd_data;
                end
            end else begin
                shared_data_oe  <= 1'b1;
                shared_data_out <= disp_data;
            end
            ext_transceiver_gate <= ~(access | load_low);
            if (load_rise) begin
                config_data <= shared_data_in;
                config_addr <= register_select_in;
            end
        end
    end

    // -------------------------------------------------------------------------
    // Display sequencer
    // -------------------------------------------------------------------------
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            disp_state_reg <= ST_IDLE;
            slot_cnt_reg   <= 4'h0;
            test_cnt_reg   <= 16'h0000;
            display_latch_strobe_lo <= 1'b1;
            display_latch_strobe_hi <= 1'b1;
        end else if (load_low) begin
            disp_state_reg <= ST_IDLE;
            slot_cnt_reg   <= 4'h0;
            test_cnt_reg   <= 16'h0000;
            display_latch_strobe_lo <= 1'b1;
            display_latch_strobe_hi <= 1'b1;
        end else begin
            if (load_rise) begin
                test_cnt_reg <= TEST_CYCLES;
            end else if (in_test) begin
                test_cnt_reg <= test_cnt_reg - 16'h0001;
            end
            display_latch_strobe_lo <= 1'b1;
            display_latch_strobe_hi <= 1'b1;
            if (access) begin
                // Sequencer freezes; strobes stay high.
                disp_state_reg <= disp_state_reg;
            end else if (slot_cnt_reg != 4'h0) begin
                slot_cnt_reg <= slot_cnt_reg - 4'h1;
            end else begin
                slot_cnt_reg <= SLOT_RELOAD[3:0];
                case (disp_state_reg)
                    ST_IDLE: begin
                        disp_state_reg <= ST_PUT_A;
                    end
                    ST_PUT_A: begin
                        display_latch_strobe_lo <= 1'b0;
                        disp_state_reg <= full_mode ? ST_PUT_B : ST_IDLE;
                    end
                    ST_PUT_B: begin
                        display_latch_strobe_hi <= 1'b0;
                        disp_state_reg <= ST_IDLE;
                    end
                    default: begin
                        disp_state_reg <= ST_IDLE;
                    end
                endcase
            end
        end
    end

    // -------------------------------------------------------------------------
    // Decrement synchroniser and event counters
    // -------------------------------------------------------------------------
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            dec_meta_reg <= 1'b1;
            dec_sync_reg <= 1'b1;
            dec_prev_reg <= 1'b1;
            dec_pend_reg <= 1'b0;
            for (i = 0; i < NUM_PORTS; i = i + 1) begin
                cnt_mem[i] <= {CNT_WIDTH{1'b0}};
            end
        end else if (load_low) begin
            dec_pend_reg <= 1'b0;
            for (i = 0; i < NUM_PORTS; i = i + 1) begin
                cnt_mem[i] <= {CNT_WIDTH{1'b0}};
            end
        end else begin
            dec_meta_reg <= counter_down_strobe_n;
            dec_sync_reg <= dec_meta_reg;
            dec_prev_reg <= dec_sync_reg;
            if (int_count) begin
                // Internal counting wins; decrement waits.
                if (dec_edge) begin
                    dec_pend_reg <= 1'b1;
                end
                for (i = 0; i < NUM_PORTS; i = i + 1) begin
                    if (port_event_in[i]) begin
                        cnt_mem[i] <= cnt_mem[i] + 1'b1;
                    end
                end
            end else if (dec_edge || dec_pend_reg) begin
                dec_pend_reg <= dec_edge & dec_pend_reg;
                for (i = 0; i < NUM_PORTS; i = i + 1) begin
                    cnt_mem[i] <= cnt_mem[i] - 1'b1;
                end
            end
        end
    end

    // -------------------------------------------------------------------------
    // Masks, sticky flags and interrupt outputs
    // -------------------------------------------------------------------------
    // Event arrival wins over a clear in the same cycle.
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            evt_mask_lo_reg <= `MASK_RESET;
            evt_mask_hi_reg <= 5'h1f;
            rt_mask_reg     <= `MASK_RESET;
            evt_flags_reg   <= 13'h0000;
            rt_status_reg   <= 8'h00;
            event_log_irq_n <= 1'b1;
            packet_irq_n    <= 1'b1;
        end else if (load_low) begin
            evt_flags_reg   <= 13'h0000;
            rt_status_reg   <= 8'h00;
            event_log_irq_n <= 1'b1;
            packet_irq_n    <= 1'b1;
        end else begin
            if (wr_take) begin
                case (register_select_in)
                    `REG_EVT_MASK:    evt_mask_lo_reg <= shared_data_in;
                    `REG_EVT_MASK_HI: evt_mask_hi_reg <= shared_data_in[4:0];
                    `REG_RT_MASK:     rt_mask_reg <= shared_data_in;
                    default:          rt_mask_reg <= rt_mask_reg;
                endcase
            end
            for (i = 0; i < NUM_PORTS; i = i + 1) begin
                if (port_event_in[i]) begin
                    evt_flags_reg[i] <= 1'b1;
                end else if ((rd_start || wr_start) && is_cnt(register_select_in)
                             && register_select_in[3:0] == i) begin
                    evt_flags_reg[i] <= 1'b0;
                end else if ((rd_start || wr_start) && (register_select_in == `REG_EVT_FLAGS
                             || register_select_in == `REG_EVT_FLAGS_HI)) begin
                    evt_flags_reg[i] <= 1'b0;
                end
            end
            if (rd_start && register_select_in == `REG_RT_STATUS) begin
                rt_status_reg <= packet_event_in;
            end else begin
                rt_status_reg <= rt_status_reg | packet_event_in;
            end
            event_log_irq_n <= ~|(evt_flags_reg & {evt_mask_hi_reg, evt_mask_lo_reg});
            packet_irq_n    <= ~|(rt_status_reg & rt_mask_reg);
        end
    end

endmodule

// ==== host_port_display_mux_props.sv ====
// Concurrent checks on the processor bus and display port.
`timescale 1ns/10ps
module host_port_display_mux_props (
    // Clock and reset.
    input wire       clk_sys,
    input wire       rst,
    // Processor bus inputs.
    input wire [4:0] register_select_in,
    input wire       rd_n,
    input wire       wr_n,
    input wire       reset_config_load_n,
    input wire [7:0] shared_data_in,
    // Observed outputs.
    input wire       shared_data_oe,
    input wire       display_latch_strobe_lo,
    input wire       display_latch_strobe_hi,
    input wire       ext_transceiver_gate,
    input wire       ready_n,
    input wire [7:0] config_data,
    input wire [4:0] config_addr
);
    // -------------------------------------------------------------
    // One clock domain, so clocking and disable are shared.
    // -------------------------------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    a_strobe_quiet: assert property ((!rd_n || !wr_n) [*2] |-> display_latch_strobe_lo && display_latch_strobe_hi)
        else $error("latch strobe low during an access");
    a_hi_unused: assert property (!$past(config_data[0]) && !config_data[0] |-> display_latch_strobe_hi)
        else $error("high strobe pulsed in reduced mode");
    a_gate_access: assert property ((!rd_n || !wr_n) |=> !ext_transceiver_gate)
        else $error("transceiver gate high during an access");
    a_display_drive: assert property ((rd_n && wr_n && reset_config_load_n) [*3] |-> shared_data_oe && ext_transceiver_gate)
        else $error("pins not driving display while idle");
    a_ready_read: assert property ((!rd_n) [*3] |-> !ready_n && shared_data_oe)
        else $error("read not answered with driven data");
    a_ready_write: assert property ((!wr_n) [*3] |-> !ready_n && !shared_data_oe)
        else $error("write not answered or pins driven");
    a_ready_release: assert property ((rd_n && wr_n) [*2] |-> ready_n)
        else $error("ready still low after strobe release");
    a_load_hold: assert property (!reset_config_load_n |=> !ext_transceiver_gate && !shared_data_oe)
        else $error("pins or gate active during load");
    a_config_take: assert property ($rose(reset_config_load_n) |=> config_data == $past(shared_data_in) && config_addr == $past(register_select_in))
        else $error("configuration not captured on load rise");
endmodule

bind host_port_display_mux host_port_display_mux_props u_props (
    .clk_sys(clk_sys), .rst(rst), .register_select_in(register_select_in), .rd_n(rd_n), .wr_n(wr_n),
    .reset_config_load_n(reset_config_load_n), .shared_data_in(shared_data_in), .shared_data_oe(shared_data_oe),
    .display_latch_strobe_lo(display_latch_strobe_lo), .display_latch_strobe_hi(display_latch_strobe_hi),
    .ext_transceiver_gate(ext_transceiver_gate), .ready_n(ready_n), .config_data(config_data),
    .config_addr(config_addr));

// ==== host_port_display_partner.sv ====
// Data bus resolution and external display latches.
`timescale 1ns/10ps
module host_port_display_partner (
    // Clock and reset.
    input  wire       clk_sys,
    input  wire       rst,
    // Drivers of the shared pins.
    input  wire       host_oe,
    input  wire [7:0] host_d,
    input  wire       dev_oe,
    input  wire [7:0] dev_d,
    // Latch strobes, active low.
    input  wire       str_lo_n,
    input  wire       str_hi_n,
    // Resolved pins and latch contents.
    output wire [7:0] bus,
    output reg  [7:0] lat_lo,
    output reg  [7:0] lat_hi
);
    reg [7:0] last_reg;  // Last resolved level.

    // No pull on the pins, so an undriven bus toggles to hide stale data.
    assign bus = dev_oe ? dev_d : (host_oe ? host_d : ~last_reg);

    // Latches load on each clock edge inside a strobe pulse.
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            last_reg <= 8'h00;
            lat_lo   <= 8'h00;
            lat_hi   <= 8'h00;
        end else begin
            last_reg <= bus;
            if (!str_lo_n) begin
                lat_lo <= bus;
            end
            if (!str_hi_n) begin
                lat_hi <= bus;
            end
        end
    end
endmodule

// ==== host_port_display_mux_tb.sv ====
// Self-checking bench for the processor bus and display port.
`timescale 1ns/10ps
`include "host_port_defs.vh"
module host_port_display_mux_tb;
    reg         clk_sys = 1'b0;
    reg         rst     = 1'b1;
    reg  [4:0]  sel     = 5'h00;   // Never floats, even when idle.
    reg         rd_n    = 1'b1;
    reg         wr_n    = 1'b1;
    reg         load_n  = 1'b1;
    reg         counter_down_strobe_n_n  = 1'b1;
    reg  [7:0]  host_d  = 8'h00;
    reg         host_oe = 1'b0;
    reg  [12:0] port_ev = 13'h0000;
    reg  [7:0]  pkt_ev  = 8'h00;
    reg  [12:0] port_disp = 13'h0000;
    reg  [7:0]  dev_disp  = 8'h3c;
    wire [7:0]  bus, d_out, lat_lo, lat_hi, config_data;
    wire [4:0]  config_addr;
    wire        d_oe, str_lo, str_hi, gate, ready_n, eli_n, rti_n;
    integer     errors = 0;
    integer     check_count = 0;
    integer     cyc = 0;

    always #12.5 clk_sys = ~clk_sys;

    // Short display test keeps the run brief.
    host_port_display_mux #(.TEST_CYCLES(16'h0010)) DUT (
        .clk_sys(clk_sys), .rst(rst), .register_select_in(sel), .rd_n(rd_n), .wr_n(wr_n),
        .reset_config_load_n(load_n), .counter_down_strobe_n(counter_down_strobe_n_n), .shared_data_in(bus),
        .shared_data_out(d_out), .shared_data_oe(d_oe), .display_latch_strobe_lo(str_lo),
        .display_latch_strobe_hi(str_hi), .ext_transceiver_gate(gate), .ready_n(ready_n),
        .event_log_irq_n(eli_n), .packet_irq_n(rti_n), .port_event_in(port_ev), .packet_event_in(pkt_ev),
        .port_disp_in(port_disp), .device_disp_in(dev_disp), .config_data(config_data), .config_addr(config_addr));

    host_port_display_partner far_end (
        .clk_sys(clk_sys), .rst(rst), .host_oe(host_oe), .host_d(host_d), .dev_oe(d_oe), .dev_d(d_out),
        .str_lo_n(str_lo), .str_hi_n(str_hi), .bus(bus), .lat_lo(lat_lo), .lat_hi(lat_hi));

    // ----------------------------------------------------------------
    // Shared tasks
    // ----------------------------------------------------------------
    task chk(input [7:0] s, input [7:0] e);
        begin
            check_count = check_count + 1;
            if (s !== e) begin
                errors = errors + 1;
                $display("[FAIL] t=%0t seen %h expected %h", $time, s, e);
            end
        end
    endtask

    task stop_test;
        begin
            $display("checks %0d mismatches %0d", check_count, errors);
            if (errors == 0 && check_count > 0)
                $display("STATUS OK");
            else
                $display("STATUS NOT OK");
            $finish;
        end
    endtask

    // Bounded wait for ready; a hung handshake costs a mismatch, not the run.
    task wait_rdy;
        integer n;
        begin
            n = 0;
            @(posedge clk_sys);
            while (ready_n !== 1'b0 && n < 10) begin
                @(posedge clk_sys);
                n = n + 1;
            end
            chk({7'h0, ready_n}, 8'h00);
        end
    endtask

    // Write data stays on the pins until ready has fallen.
    task wr_reg(input [4:0] a, input [7:0] d);
        begin
            sel     <= a;
            host_d  <= d;
            host_oe <= 1'b1;
            wr_n    <= 1'b0;
            wait_rdy();
            wr_n    <= 1'b1;
            host_oe <= 1'b0;
            @(posedge clk_sys);
        end
    endtask

    task rd_chk(input [4:0] a, input [7:0] e);
        begin
            sel  <= a;
            rd_n <= 1'b0;
            wait_rdy();
            chk(bus, e);
            rd_n <= 1'b1;
            @(posedge clk_sys);
        end
    endtask

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task t_load(input [7:0] d, input [4:0] a);
        begin
            host_d  <= d;
            sel     <= a;
            host_oe <= 1'b1;
            load_n  <= 1'b0;
            repeat (4) @(posedge clk_sys);
            load_n  <= 1'b1;
            @(posedge clk_sys);
            host_oe <= 1'b0;
            repeat (2) @(posedge clk_sys);
            chk(config_data, d);
            chk({3'h0, config_addr}, {3'h0, a});
            repeat (9) @(posedge clk_sys);
            chk(lat_lo, `DISP_TEST_DATA);
            $display("done: load");
        end
    endtask

    task t_display(input [12:0] p);
        begin
            port_disp <= p;
            repeat (40) @(posedge clk_sys);
            chk(lat_lo, {1'b0, p[6:0]});
            chk(lat_hi, `PORT_HI_TAG | {2'h0, p[12:7]});
            $display("done: display");
        end
    endtask

    // Counting, masking, clearing and a decrement that meets counting.
    task t_events;
        begin
            port_ev <= 13'h0008;
            repeat (3) @(posedge clk_sys);
            port_ev <= 13'h0000;
            repeat (4) @(posedge clk_sys);
            chk({7'h0, eli_n}, 8'h00);
            rd_chk(`REG_EVT_FLAGS, 8'h08);
            chk({7'h0, eli_n}, 8'h01);
            rd_chk(5'h03, 8'h03);
            wr_reg(`REG_EVT_MASK, 8'h00);
            rd_chk(`REG_EVT_MASK, 8'h00);
            port_ev <= 13'h0008;
            @(posedge clk_sys);
            port_ev <= 13'h0000;
            repeat (4) @(posedge clk_sys);
            chk({7'h0, eli_n}, 8'h01);
            wr_reg(`REG_EVT_MASK, 8'hff);
            port_ev <= 13'h0020;
            counter_down_strobe_n_n  <= 1'b0;
            @(posedge clk_sys);
            counter_down_strobe_n_n  <= 1'b1;
            repeat (2) @(posedge clk_sys);
            port_ev <= 13'h0000;
            repeat (6) @(posedge clk_sys);
            rd_chk(5'h03, 8'h03);
            rd_chk(5'h05, 8'h02);
            rd_chk(5'h1e, 8'h00);
            $display("done: events");
        end
    endtask

    task t_rt;
        begin
            pkt_ev <= 8'h04;
            @(posedge clk_sys);
            pkt_ev <= 8'h00;
            repeat (4) @(posedge clk_sys);
            chk({7'h0, rti_n}, 8'h00);
            rd_chk(`REG_RT_STATUS, 8'h04);
            chk({7'h0, rti_n}, 8'h01);
            wr_reg(`REG_RT_MASK, 8'h00);
            pkt_ev <= 8'h04;
            @(posedge clk_sys);
            pkt_ev <= 8'h00;
            repeat (4) @(posedge clk_sys);
            chk({7'h0, rti_n}, 8'h01);
            $display("done: realtime");
        end
    endtask

    // Reduced mode shows device data; the load also clears the counters.
    task t_reduced;
        begin
            t_load(8'h00, 5'h03);
            repeat (40) @(posedge clk_sys);
            chk(lat_lo, dev_disp);
            rd_chk(5'h03, 8'h00);
            $display("done: reduced");
        end
    endtask

    // Hang guard, far above the few hundred cycles the run needs.
    always @(posedge clk_sys) begin
        cyc = cyc + 1;
        if (cyc == 20000) begin
            errors = errors + 1;
            stop_test();
        end
    end

    initial begin
        repeat (12) @(posedge clk_sys);
        rst <= 1'b0;
        @(posedge clk_sys);
        t_load(8'h01, 5'h0a);
        t_display(13'h1a5a);
        t_events;
        t_rt;
        t_display(13'h0c35);
        t_reduced;
        stop_test();
    end
endmodule
